// ==== core/acm_regmap.sv ====
// Serial-port register map of the converter: framing, registers, commit and power mode
//
// How it works
// - Decodes 0x00-0x02, commit register 0xFF and function registers 0x08-0x2A.
// - Overrange setup resets to 0x01; clearing bit 0 disables overrange output.
// - Reset preloads each critical register with its listed default.
// - Registers without a default keep their contents through reset.
// - Address 0x01 returns a fixed read-only identification byte.
// - Address 0x02 is read-only: zeros, speed grade in bits 4:3.
// - Commit bit copies written settings into the active registers.
// - Power-down field bits 2:0 selects normal, full power-down or standby.
// - Asserted power-down pin overrides; mode bit 5 picks full or standby.
// - Shifting is MSB first until the host selects LSB first.
`timescale 1ns/1ps
`include "acm_cfg.svh"

module acm_regmap
  import acm_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value, not a real part code
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic powerdown_pin,
  output acm_power_t power_state,
  output logic overrange_enable,
  output logic lsb_first
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  acm_phase_t phase, next_phase;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [15:0] shift_in, next_shift_in;
  logic is_read, next_is_read;
  logic stream, next_stream;
  logic [1:0] bytes_left, next_bytes_left;
  logic [12:0] addr, next_addr;
  logic [7:0] tx_byte, next_tx_byte;
  logic next_sdio_out, next_sdio_oe;
  logic sclk_q;
  logic next_lsb_first;
  logic [7:0] mode_master, next_mode_master;
  logic [7:0] ovr_master, next_ovr_master;
  logic [7:0] mode_active, next_mode_active;
  logic [7:0] ovr_active, next_ovr_active;
  acm_power_t next_power_state;
  logic [7:0] mem [`ACM_MEM_LO:`ACM_MEM_HI];
  logic mem_we;
  logic [7:0] wr_data;
  logic sclk_rise, sclk_fall;

  assign sclk_rise = !csb_n && sclk && !sclk_q;
  assign sclk_fall = !csb_n && !sclk && sclk_q;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [7:0] read_reg(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `ACM_ADDR_PORT) begin
      v = `ACM_RST_PORT;
      v[`ACM_PORT_LSB_HI] = lsb_first;
      v[`ACM_PORT_LSB_LO] = lsb_first;
    end else if (a == `ACM_ADDR_ID) begin
      v = PART_ID;
    end else if (a == `ACM_ADDR_GRADE) begin
      v = {3'h0, SPEED_GRADE, 3'h0};
    end else if (a == `ACM_ADDR_MODE) begin
      v = mode_master;
    end else if (a == `ACM_ADDR_OVR) begin
      v = ovr_master;
    end else if (a[12:8] == 5'h00 && a[7:0] >= `ACM_MEM_LO && a[7:0] <= `ACM_MEM_HI) begin
      v = mem[a[7:0]];
    end
    return v;
  endfunction

  // ----------------------------------------
  // Framing and register writes
  // ----------------------------------------
  always_comb begin
    logic [15:0] sh;
    logic [7:0] got;
    sh = 16'h0000;
    got = 8'h00;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_is_read = is_read;
    next_stream = stream;
    next_bytes_left = bytes_left;
    next_addr = addr;
    next_tx_byte = tx_byte;
    next_sdio_out = sdio_out;
    next_sdio_oe = sdio_oe;
    next_lsb_first = lsb_first;
    next_mode_master = mode_master;
    next_ovr_master = ovr_master;
    next_mode_active = mode_active;
    next_ovr_active = ovr_active;
    mem_we = 1'b0;
    wr_data = 8'h00;
    if (csb_n) begin
      next_phase = ACM_INSTR;
      next_bit_cnt = 4'h0;
      next_sdio_oe = 1'b0;
    end else if (sclk_rise && phase != ACM_HOLD) begin
      sh = lsb_first ? {sdio_in, shift_in[15:1]} : {shift_in[14:0], sdio_in};
      got = lsb_first ? sh[15:8] : sh[7:0];
      next_shift_in = sh;
      next_bit_cnt = bit_cnt + 4'h1;
      if (phase == ACM_INSTR && bit_cnt == `ACM_INS_LAST) begin
        next_phase = ACM_DATA;
        next_bit_cnt = 4'h0;
        next_is_read = sh[`ACM_INS_RW];
        next_bytes_left = sh[`ACM_INS_CNT_HI:`ACM_INS_CNT_LO];
        next_stream = sh[`ACM_INS_CNT_HI:`ACM_INS_CNT_LO] == `ACM_CNT_STREAM;
        next_addr = sh[`ACM_INS_ADDR_HI:0];
        next_tx_byte = read_reg(sh[`ACM_INS_ADDR_HI:0]);
      end else if (phase == ACM_DATA && bit_cnt == `ACM_BYTE_LAST) begin
        next_bit_cnt = 4'h0;
        next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
        next_tx_byte = read_reg(next_addr);
        if (!stream && bytes_left == 2'h0) begin
          next_phase = ACM_HOLD;
        end else if (!stream) begin
          next_bytes_left = bytes_left - 2'h1;
        end
        if (!is_read) begin
          wr_data = got;
          if (addr == `ACM_ADDR_PORT) begin
            next_lsb_first = got[`ACM_PORT_LSB_HI] | got[`ACM_PORT_LSB_LO];
            if (got[`ACM_PORT_SRST_HI] | got[`ACM_PORT_SRST_LO]) begin
              // Soft reset is never stored, so it reads back as zero
              next_lsb_first = 1'b0;
              next_mode_master = `ACM_RST_MODE;
              next_ovr_master = `ACM_RST_OVR;
              next_mode_active = `ACM_RST_MODE;
              next_ovr_active = `ACM_RST_OVR;
            end
          end else if (addr == `ACM_ADDR_MODE) begin
            next_mode_master = got;
          end else if (addr == `ACM_ADDR_OVR) begin
            next_ovr_master = got;
          end else if (addr == `ACM_ADDR_COMMIT) begin
            // Commit acts once and leaves nothing stored
            if (got[`ACM_COMMIT_BIT]) begin
              next_mode_active = mode_master;
              next_ovr_active = ovr_master;
            end
          end else if (addr[12:8] == 5'h00 && addr[7:0] >= `ACM_MEM_LO
                       && addr[7:0] <= `ACM_MEM_HI) begin
            mem_we = 1'b1;
          end
        end
      end
    end else if (sclk_fall && phase == ACM_DATA && is_read) begin
      // Drive on the falling edge so data is stable at the host's rising edge
      next_sdio_oe = 1'b1;
      next_sdio_out = lsb_first ? tx_byte[0] : tx_byte[7];
      next_tx_byte = lsb_first ? {1'b0, tx_byte[7:1]} : {tx_byte[6:0], 1'b0};
    end else if (sclk_fall && phase == ACM_HOLD) begin
      next_sdio_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // Power mode
  // ----------------------------------------
  always_comb begin
    unique case (mode_active[`ACM_MODE_PD_HI:`ACM_MODE_PD_LO])
      `ACM_PD_FULL: next_power_state = ACM_FULL_PD;
      `ACM_PD_STANDBY: next_power_state = ACM_STANDBY;
      default: next_power_state = ACM_RUN;
    endcase
    if (powerdown_pin) begin
      next_power_state = mode_active[`ACM_MODE_PIN_SEL] ? ACM_STANDBY : ACM_FULL_PD;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase <= ACM_INSTR;
      bit_cnt <= 4'h0;
      shift_in <= 16'h0000;
      is_read <= 1'b0;
      stream <= 1'b0;
      bytes_left <= 2'h0;
      addr <= 13'h0000;
      tx_byte <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      sclk_q <= 1'b0;
      lsb_first <= 1'b0;
      mode_master <= `ACM_RST_MODE;
      ovr_master <= `ACM_RST_OVR;
      mode_active <= `ACM_RST_MODE;
      ovr_active <= `ACM_RST_OVR;
      power_state <= ACM_RUN;
      overrange_enable <= 1'b1;
    end else begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      is_read <= next_is_read;
      stream <= next_stream;
      bytes_left <= next_bytes_left;
      addr <= next_addr;
      tx_byte <= next_tx_byte;
      sdio_out <= next_sdio_out;
      sdio_oe <= next_sdio_oe;
      sclk_q <= sclk;
      lsb_first <= next_lsb_first;
      mode_master <= next_mode_master;
      ovr_master <= next_ovr_master;
      mode_active <= next_mode_active;
      ovr_active <= next_ovr_active;
      power_state <= next_power_state;
      overrange_enable <= ovr_active[`ACM_OVR_EN_BIT];
    end
  end

  // No reset here: these locations keep their contents across reset
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[addr[7:0]] <= wr_data;
    end
  end

endmodule

// ==== core/acm_cfg.svh ====
// Addresses, reset values, field positions and codes of the converter register map
`ifndef ACM_CFG_SVH
`define ACM_CFG_SVH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define ACM_ADDR_PORT 13'h0000
`define ACM_ADDR_ID 13'h0001
`define ACM_ADDR_GRADE 13'h0002
`define ACM_ADDR_MODE 13'h0008
`define ACM_ADDR_OVR 13'h002A
`define ACM_ADDR_COMMIT 13'h00FF
`define ACM_MEM_LO 8'h09
`define ACM_MEM_HI 8'h29

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACM_RST_PORT 8'h18
`define ACM_RST_MODE 8'h00
`define ACM_RST_OVR 8'h01
`define ACM_RST_COMMIT 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACM_PORT_LSB_HI 6
`define ACM_PORT_LSB_LO 1
`define ACM_PORT_SRST_HI 5
`define ACM_PORT_SRST_LO 2
`define ACM_COMMIT_BIT 0
`define ACM_OVR_EN_BIT 0
`define ACM_MODE_PIN_SEL 5
`define ACM_MODE_PD_HI 2
`define ACM_MODE_PD_LO 0
`define ACM_INS_RW 15
`define ACM_INS_CNT_HI 14
`define ACM_INS_CNT_LO 13
`define ACM_INS_ADDR_HI 12

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define ACM_PD_NORMAL 3'h0
`define ACM_PD_FULL 3'h1
`define ACM_PD_STANDBY 3'h2
`define ACM_PD_NORMAL2 3'h3
`define ACM_CNT_STREAM 2'h3
`define ACM_INS_LAST 4'hF
`define ACM_BYTE_LAST 4'h7

`endif

// ==== core/acm_pkg.sv ====
// Types shared by the converter register map
package acm_pkg;
  typedef enum logic [1:0] {ACM_INSTR, ACM_DATA, ACM_HOLD} acm_phase_t;
  typedef enum logic [1:0] {ACM_RUN, ACM_FULL_PD, ACM_STANDBY} acm_power_t;
endpackage

// ==== verif/acm_regmap_monitor.sv ====
// Assertion checker bound to the converter register map
`timescale 1ns/1ps
module acm_regmap_monitor
  import acm_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic powerdown_pin,
  input wire acm_power_t power_state,
  input wire logic overrange_enable,
  input wire logic lsb_first
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  reset_vals_a: assert property ($rose(reset_n) |-> power_state == ACM_RUN
    && overrange_enable && !lsb_first && !sdio_oe) else $error("bad reset values");
  // Pin may pass a synchroniser, so up to three clocks of latency are allowed
  pin_override_a: assert property (powerdown_pin [*4] |-> power_state != ACM_RUN)
    else $error("pin ignored");
  state_hold_a: assert property (csb_n && $past(csb_n) && !powerdown_pin
    && !$past(powerdown_pin) && !$past(powerdown_pin, 2) && !$past(powerdown_pin, 3)
    |-> $stable(power_state)) else $error("state moved while idle");
  oe_idle_a: assert property (csb_n [*2] |-> !sdio_oe) else $error("drives idle");
  oe_start_a: assert property ($rose(sdio_oe) |-> !csb_n && !sclk)
    else $error("bad drive start");
  bit_hold_a: assert property (sdio_oe && sclk && $past(sclk) |-> $stable(sdio_out))
    else $error("read bit moved");
  order_move_a: assert property ($changed(lsb_first) |-> !$past(csb_n))
    else $error("order moved idle");
  ovr_move_a: assert property ($changed(overrange_enable) |-> !$past(csb_n, 2))
    else $error("enable moved idle");
  cover property (powerdown_pin [*4]);
  cover property ($rose(sdio_oe));
  cover property ($fell(overrange_enable));
endmodule
bind acm_regmap acm_regmap_monitor acm_regmap_monitor_i (
  .clock(clock),
  .reset_n(reset_n),
  .sclk(sclk),
  .csb_n(csb_n),
  .sdio_out(sdio_out),
  .sdio_oe(sdio_oe),
  .powerdown_pin(powerdown_pin),
  .power_state(power_state),
  .overrange_enable(overrange_enable),
  .lsb_first(lsb_first)
);

// ==== verif/acm_host.sv ====
// Host serial-port controller model for the converter register map
`timescale 1ns/1ps
module acm_host (
  input wire logic clock,
  output logic sclk,
  output logic csb_n,
  output logic sdio_drv,
  input wire logic sdio_line
);
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_drv = 1'b0;
  end
  // Instruction word then nb bytes, byte 0 in bits 15:8 of wd and rd
  // Clock rests low and data toggles between frames
  task automatic xfer(input logic lsb, input logic [15:0] ins, input logic [15:0] wd,
                      input int nb, output logic [15:0] rd);
    int k;
    int j;
    rd = 16'h0000;
    csb_n <= 1'b0;
    for (int i = 0; i <= 16 + 8 * nb; i++) begin
      k = (i - 16) / 8;
      j = lsb ? (i - 16) % 8 : 7 - (i - 16) % 8;
      sclk <= 1'b0;
      if (i < 16)
        sdio_drv <= ins[lsb ? i : 15 - i];
      else if (i < 16 + 8 * nb)
        sdio_drv <= wd[8 - 8 * k + j];
      // Three low clocks let the read bit settle after the falling edge
      repeat (3) @(negedge clock);
      if (i >= 16 && i < 16 + 8 * nb)
        rd[8 - 8 * k + j] = sdio_line;
      sclk <= (i < 16 + 8 * nb);
      repeat (2) @(negedge clock);
    end
    csb_n <= 1'b1;
    sdio_drv <= ~sdio_drv;
    repeat (2) @(negedge clock);
  endtask
endmodule

// ==== verif/acm_regmap_test.sv ====
// Self-checking testbench for the converter register map
`timescale 1ns/1ps
module acm_regmap_test
  import acm_pkg::*;
;
  localparam logic [7:0] ID = 8'h5C; // Arbitrary identification byte
  logic clock, reset_n, sclk, csb_n, sdio_drv, sdio_out, sdio_oe, powerdown_pin;
  logic overrange_enable, lsb_first, lsb_mode;
  acm_power_t power_state;
  int n_fail, tests_run;
  // The block owns the shared data line while its enable is high
  wire logic sdio_in = sdio_oe ? sdio_out : sdio_drv;
  acm_regmap #(.PART_ID(ID)) acm_regmap_i (
    .clock(clock),
    .reset_n(reset_n),
    .sclk(sclk),
    .csb_n(csb_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .powerdown_pin(powerdown_pin),
    .power_state(power_state),
    .overrange_enable(overrange_enable),
    .lsb_first(lsb_first)
  );
  // The host samples the shared line, so a missing drive enable shows up as wrong data
  acm_host acm_host_i (
    .clock(clock),
    .sclk(sclk),
    .csb_n(csb_n),
    .sdio_drv(sdio_drv),
    .sdio_line(sdio_in)
  );
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic rd, input logic [12:0] a, input logic [7:0] d);
    logic [15:0] r;
    // A read drives the inverse, so a released line cannot pass for read data
    acm_host_i.xfer(lsb_mode, {rd, 2'h0, a}, {rd ? ~d : d, 8'h00}, 1, r);
    if (rd)
      chk($sformatf("reg %h", a), r[15:8], d);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_map;
    acc(1'b1, 13'h0000, 8'h18);
    acc(1'b1, 13'h0008, 8'h00);
    acc(1'b1, 13'h00FF, 8'h00);
    acc(1'b0, 13'h0001, ~ID);
    acc(1'b1, 13'h0001, ID);
    acc(1'b1, 13'h0002, 8'h00);
    acc(1'b1, 13'h0005, 8'h00);
    $display("map test done");
  endtask
  task automatic t_ovr;
    acc(1'b1, 13'h002A, 8'h01);
    acc(1'b0, 13'h002A, 8'h00);
    chk("overrange_enable", {7'h0, overrange_enable}, 8'h01);
    acc(1'b0, 13'h00FF, 8'h01);
    chk("overrange_enable", {7'h0, overrange_enable}, 8'h00);
    acc(1'b1, 13'h00FF, 8'h00);
    $display("overrange test done");
  endtask
  task automatic t_power;
    acm_power_t e;
    // Codes 0 to 3 alone, then the pin with each choice of its mode bit
    for (int c = 0; c < 6; c++) begin
      e = (c == 1 || c == 4) ? ACM_FULL_PD : (c == 2 || c == 5) ? ACM_STANDBY : ACM_RUN;
      powerdown_pin <= c > 3;
      acc(1'b0, 13'h0008, c < 4 ? 8'(c) : c == 5 ? 8'h20 : 8'h00);
      acc(1'b0, 13'h00FF, 8'h01);
      chk("power_state", {6'h0, power_state}, {6'h0, e});
    end
    powerdown_pin <= 1'b0;
    repeat (5) @(negedge clock);
    chk("power_state", {6'h0, power_state}, {6'h0, ACM_RUN});
    $display("power test done");
  endtask
  task automatic t_retain;
    acc(1'b0, 13'h000B, 8'h5A);
    reset_n <= 1'b0;
    repeat (2) @(negedge clock);
    reset_n <= 1'b1;
    repeat (2) @(negedge clock);
    acc(1'b1, 13'h000B, 8'h5A);
    acc(1'b1, 13'h0008, 8'h00);
    chk("overrange_enable", {7'h0, overrange_enable}, 8'h01);
    $display("retain test done");
  endtask
  task automatic t_lsb;
    acc(1'b0, 13'h0000, 8'h5A);
    chk("lsb_first", {7'h0, lsb_first}, 8'h01);
    lsb_mode = 1'b1;
    acc(1'b1, 13'h0000, 8'h5A);
    acc(1'b1, 13'h0001, ID);
    acc(1'b0, 13'h0000, 8'h3C);
    lsb_mode = 1'b0;
    chk("lsb_first", {7'h0, lsb_first}, 8'h00);
    acc(1'b1, 13'h0000, 8'h18);
    $display("shift order test done");
  endtask
  task automatic t_multi;
    logic [15:0] r;
    // Streamed write walks down in MSB-first order, a counted read walks down again from 0x0C
    acm_host_i.xfer(1'b0, {1'b0, 2'h3, 13'h000C}, 16'h1122, 2, r);
    acm_host_i.xfer(1'b0, {1'b1, 2'h1, 13'h000C}, 16'hEEDD, 2, r);
    chk("reg 000c", r[15:8], 8'h11);
    chk("reg 000b", r[7:0], 8'h22);
    // LSB-first order walks the address upwards instead
    acc(1'b0, 13'h0000, 8'h5A);
    lsb_mode = 1'b1;
    acm_host_i.xfer(1'b1, {1'b1, 2'h1, 13'h000B}, 16'hDDEE, 2, r);
    chk("reg 000b", r[15:8], 8'h22);
    chk("reg 000c", r[7:0], 8'h11);
    acc(1'b0, 13'h0000, 8'h18);
    lsb_mode = 1'b0;
    chk("lsb_first", {7'h0, lsb_first}, 8'h00);
    $display("multi-byte test done");
  endtask
  initial begin
    reset_n = 1'b0;
    powerdown_pin = 1'b0;
    lsb_mode = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (2) @(negedge clock);
    reset_n <= 1'b1;
    repeat (2) @(negedge clock);
    t_map;
    t_ovr;
    t_power;
    t_retain;
    t_lsb;
    t_multi;
    end_sim;
  end
  initial begin
    repeat (50000) @(posedge clock);
    n_fail++;
    end_sim;
  end
endmodule
